// file: serial_mode_pkg.sv
// Package for the serial port mode-control block.
// Assumes a 32-bit APB slave at 10 MHz pclk.
package serial_mode_pkg;

    // ==========================================
    // Register map
    localparam logic [7:0] MODE_OFFSET = 8'h00;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h08;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;

    // ==========================================
    // Mode register fields
    localparam int SLEEP_RUN_POS = 23;
    localparam int ACTIVE_POS = 22;
    localparam int BAUD_CLOCK_SELECT_LO_POS = 17;
    localparam int RUN_OVF_POS = 16;
    localparam int ENABLE_POS = 15;
    localparam int IDLE_STOP_POS = 13;
    localparam int PIN_USAGE_LO_POS = 8;
    localparam logic [31:0] MODE_WRITE_MASK = 32'h0087_bfff;

    // ==========================================
    // Clock select codes
    localparam logic [1:0] CLK_PB2 = 2'h3;
    localparam logic [1:0] CLK_FRC = 2'h2;
    localparam logic [1:0] CLK_SYS = 2'h1;
    localparam logic [1:0] CLK_PB2_GATED = 2'h0;

    // ==========================================
    // Interrupt status bits
    localparam int IRQ_OVERRUN = 0;
    localparam int IRQ_ACTIVE_FALL = 1;
    localparam int IRQ_BITS = 2;

    typedef struct packed {
        logic sleep;
        logic deep_sleep;
        logic idle;
    } power_t;

    typedef struct packed {
        logic rx_active;
        logic tx_active;
        logic overrun;
    } engine_t;

    typedef struct packed {
        logic baud_clk_en;
        logic [1:0] clk_src;
        logic rx_shift_en;
        logic engine_run;
        logic pin_own;
        logic tx_pin_own;
        logic [1:0] pin_usage;
        logic low_power;
    } ctrl_t;

endpackage

// file: serial_mode_ctrl.sv
// Mode-control block of an asynchronous serial port, APB register slave.
// Assumes engines, baud generator and pin mux outside; inputs synchronous.
`timescale 1ns/1ns
`default_nettype none
module serial_mode_ctrl
    import serial_mode_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire serial_mode_pkg::power_t power,
    input wire serial_mode_pkg::engine_t engine,
    input wire logic transmit_enable_bit,
    input wire logic pin_remap_logic,
    output serial_mode_pkg::ctrl_t ctrl,
    output logic irq
);
    import serial_mode_pkg::*;

    typedef struct packed {
        logic [31:0] mode;
        logic [IRQ_BITS-1:0] status;
        logic [IRQ_BITS-1:0] mask;
        logic active;
        logic rx_halted;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        ctrl_t ctrl;
        logic irq;
    } state_t;

    state_t s_q;
    state_t s_d;

    // ==========================================
    // Helpers
    function automatic logic clk_runs_in_sleep(input logic [1:0] sel, input logic run_bit);
        clk_runs_in_sleep = run_bit && (sel == CLK_FRC);
    endfunction

    logic access;
    logic wr;
    logic [1:0] sel;
    logic en;
    logic running;
    logic rx_halt_d;
    always_comb
    begin
        access = psel && penable && !s_q.ready;
        // Write lands on the edge that samples pready high
        wr = psel && penable && pwrite && s_q.ready;
        s_d = s_q;
        s_d.ready = access;
        s_d.slverr = 1'b0;
        s_d.rdata = 32'h0000_0000;
        if (wr)
        begin
            case (paddr)
                MODE_OFFSET: s_d.mode = pwdata & MODE_WRITE_MASK;
                IRQ_STATUS_OFFSET: s_d.status = s_q.status & ~pwdata[IRQ_BITS-1:0];
                IRQ_MASK_OFFSET: s_d.mask = pwdata[IRQ_BITS-1:0];
                default: s_d.slverr = 1'b0;
            endcase
        end
        if (access)
        begin
            case (paddr)
                MODE_OFFSET:
                begin
                    s_d.rdata = s_q.mode & MODE_WRITE_MASK;
                    s_d.rdata[ACTIVE_POS] = s_q.active;
                end
                IRQ_STATUS_OFFSET: s_d.rdata[IRQ_BITS-1:0] = s_q.status;
                IRQ_MASK_OFFSET: s_d.rdata[IRQ_BITS-1:0] = s_q.mask;
                default: s_d.slverr = 1'b1;
            endcase
        end
        sel = s_q.mode[BAUD_CLOCK_SELECT_LO_POS +: 2];
        en = s_q.mode[ENABLE_POS];
        // Engine runs unless disabled, deep sleep, or idle with idle-stop
        running = en && !power.deep_sleep
            && !(power.idle && s_q.mode[IDLE_STOP_POS]);
        s_d.active = running && (engine.rx_active || engine.tx_active);
        // Overrun halts shifter in legacy mode until cleared or disabled
        rx_halt_d = s_q.rx_halted;
        if (!en || !engine.overrun)
            rx_halt_d = 1'b0;
        else if (!s_q.mode[RUN_OVF_POS])
            rx_halt_d = 1'b1;
        s_d.rx_halted = rx_halt_d;
        s_d.ctrl.engine_run = running;
        s_d.ctrl.rx_shift_en = running && (s_q.mode[RUN_OVF_POS] || !rx_halt_d);
        s_d.ctrl.clk_src = sel;
        if (!running)
            s_d.ctrl.baud_clk_en = 1'b0;
        else if (power.sleep)
            s_d.ctrl.baud_clk_en = clk_runs_in_sleep(sel, s_q.mode[SLEEP_RUN_POS]);
        else
            s_d.ctrl.baud_clk_en = 1'b1;
        s_d.ctrl.pin_own = en;
        s_d.ctrl.tx_pin_own = en && transmit_enable_bit;
        // Remap logic supersedes legacy pin usage
        s_d.ctrl.pin_usage = (en && !pin_remap_logic)
            ? s_q.mode[PIN_USAGE_LO_POS +: 2] : 2'h0;
        s_d.ctrl.low_power = !en;
        // Set wins over a same-cycle clear
        if (en && engine.overrun)
            s_d.status[IRQ_OVERRUN] = 1'b1;
        if (s_q.active && !s_d.active)
            s_d.status[IRQ_ACTIVE_FALL] = 1'b1;
        s_d.irq = |(s_d.status & s_d.mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.mode <= MODE_RESET;
        end
        else
            s_q <= s_d;
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.slverr;
    assign ctrl = s_q.ctrl;
    assign irq = s_q.irq;

    // ==========================================
    // Checks
    a_deep_sleep_stop: assert property (@(posedge pclk) disable iff (!presetn)
        power.deep_sleep |=> !ctrl.baud_clk_en && !ctrl.engine_run)
        else $error("clock runs in deep sleep");
    a_sleep_clk_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (power.sleep && !power.deep_sleep && running && s_q.mode[SLEEP_RUN_POS]
        && sel == CLK_FRC) |=> ctrl.baud_clk_en)
        else $error("baud clock stopped in sleep");
    a_sleep_no_run: assert property (@(posedge pclk) disable iff (!presetn)
        (power.sleep && !s_q.mode[SLEEP_RUN_POS]) |=> !ctrl.baud_clk_en)
        else $error("baud clock runs in sleep");
    a_active_status: assert property (@(posedge pclk) disable iff (!presetn)
        !en |=> !s_q.active)
        else $error("activity shown while disabled");
    a_clk_select: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> ctrl.clk_src == $past(sel))
        else $error("clock source mismatch");
    a_overrun_run: assert property (@(posedge pclk) disable iff (!presetn)
        (engine.overrun && running && s_q.mode[RUN_OVF_POS]) |=> ctrl.rx_shift_en)
        else $error("shifter stopped on overrun");
    a_overrun_halt: assert property (@(posedge pclk) disable iff (!presetn)
        (engine.overrun && en && !s_q.mode[RUN_OVF_POS]) |=> !ctrl.rx_shift_en)
        else $error("shifter ran on overrun");
    a_pin_owner: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> ctrl.pin_own == $past(en) && ctrl.low_power == !$past(en))
        else $error("pin ownership wrong");
    a_idle_halt: assert property (@(posedge pclk) disable iff (!presetn)
        (power.idle && s_q.mode[IDLE_STOP_POS]) |=> !ctrl.engine_run)
        else $error("runs in idle");
    a_remap_wins: assert property (@(posedge pclk) disable iff (!presetn)
        pin_remap_logic |=> ctrl.pin_usage == 2'h0)
        else $error("legacy pin usage not overridden");
    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && paddr == MODE_OFFSET) |-> (prdata & 32'hff38_4000) == 32'h0)
        else $error("reserved bits nonzero");
endmodule
`default_nettype wire

// file: serial_far_end.sv
// Far-end engine model: drives the line activity levels.
// Assumes the bench commands it on the shared pclk.
`timescale 1ns/1ns
`default_nettype none
module serial_far_end
    import serial_mode_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] want,
    output serial_mode_pkg::engine_t engine
);
    // ====================
    // One-cycle late status
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            engine <= '0;
        else
            engine <= engine_t'(want);
    end
endmodule
`default_nettype wire

// file: tb_serial_mode_ctrl.sv
// Bench for the serial mode-control block.
// Assumes the far-end model and package offsets.
`timescale 1ns/1ns
`default_nettype none
module tb_serial_mode_ctrl;
    import serial_mode_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, irq, tx_en = 0, remap = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, v = 32'h721d;
    logic [2:0] want = '0;
    logic [33:0] m, expq[$];
    power_t power = '0;
    engine_t engine;
    ctrl_t ctrl;
    int mismatches = 0, cmp_count = 0;
    always #50 pclk = ~pclk;
    serial_mode_ctrl i_serial_mode_ctrl(.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power(power), .engine(engine),
        .transmit_enable_bit(tx_en), .pin_remap_logic(remap), .ctrl(ctrl), .irq(irq));
    serial_far_end i_serial_far_end(.pclk(pclk), .presetn(presetn), .want(want), .engine(engine));
    // ====================
    // Shared tasks
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(string what, logic [32:0] e, logic [32:0] g);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    // Note is {check data, expected error, expected data}
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [33:0] e);
        int n;
        expq.push_back(e);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge pclk);
        if (n == 20)
        begin
            mismatches++;
            report_and_stop();
        end
        psel <= 0;
        penable <= 0;
    endtask
    task automatic st;
        repeat (2) @(posedge pclk);
    endtask
    // ====================
    // Response monitor
    always @(posedge pclk)
        if (pready === 1'b1 && expq.size() > 0)
        begin
            m = expq.pop_front();
            cmp("pslverr", 33'(m[32]), 33'(pslverr));
            if (m[33])
                cmp("prdata", 33'(m[31:0]), 33'(prdata));
        end
    // ====================
    // Main sequence
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        apb(0, MODE_OFFSET, 0, {2'b10, MODE_RESET});
        v = xs(v) | 32'hff78_4000;
        apb(1, MODE_OFFSET, v, '0);
        apb(0, MODE_OFFSET, 0, {2'b10, v & MODE_WRITE_MASK});
        power <= 3'b100;
        for (int c = 0; c < 4; c++)
        begin
            apb(1, MODE_OFFSET, 32'h0080_8000 | (c << BAUD_CLOCK_SELECT_LO_POS), '0);
            st();
            cmp("clk_src", 33'(c), 33'(ctrl.clk_src));
            if (c != 3)
                cmp("baud_clk_en", 33'(c == 2), 33'(ctrl.baud_clk_en));
        end
        apb(1, MODE_OFFSET, 32'h0004_8000, '0);
        st();
        cmp("baud_clk_en", 33'h0, 33'(ctrl.baud_clk_en));
        power <= 3'b110;
        apb(1, MODE_OFFSET, 32'h0084_8000, '0);
        st();
        cmp("baud_clk_en", 33'h0, 33'(ctrl.baud_clk_en));
        power <= '0;
        apb(1, IRQ_MASK_OFFSET, 0, '0);
        apb(1, MODE_OFFSET, 32'h0001_8000, '0);
        want <= 3'b001;
        repeat (3) @(posedge pclk);
        cmp("rx_shift_en", 33'h1, 33'(ctrl.rx_shift_en));
        cmp("irq", 33'h0, 33'(irq));
        want <= 3'b000;
        apb(1, IRQ_MASK_OFFSET, 1, '0);
        st();
        cmp("irq", 33'h1, 33'(irq));
        apb(0, IRQ_STATUS_OFFSET, 0, {2'b10, 32'h1});
        apb(1, IRQ_STATUS_OFFSET, 1, '0);
        st();
        cmp("irq", 33'h0, 33'(irq));
        apb(1, MODE_OFFSET, 32'h0000_8000, '0);
        want <= 3'b001;
        repeat (3) @(posedge pclk);
        cmp("rx_shift_en", 33'h0, 33'(ctrl.rx_shift_en));
        want <= 3'b000;
        apb(1, MODE_OFFSET, 0, '0);
        st();
        cmp("pin_own", 33'h0, 33'(ctrl.pin_own));
        cmp("low_power", 33'h1, 33'(ctrl.low_power));
        tx_en <= 1;
        apb(1, MODE_OFFSET, 32'h0000_8200, '0);
        st();
        cmp("pins", 33'h0e, 33'({ctrl.pin_own, ctrl.tx_pin_own, ctrl.pin_usage}));
        remap <= 1;
        st();
        cmp("pin_usage", 33'h0, 33'(ctrl.pin_usage));
        power <= 3'b001;
        apb(1, MODE_OFFSET, 32'h0000_a000, '0);
        st();
        cmp("engine_run", 33'h0, 33'(ctrl.engine_run));
        apb(1, MODE_OFFSET, 32'h0000_8000, '0);
        st();
        cmp("engine_run", 33'h1, 33'(ctrl.engine_run));
        power <= '0;
        want <= 3'b100;
        repeat (3) @(posedge pclk);
        apb(0, MODE_OFFSET, 0, {2'b10, 32'h0040_8000});
        apb(0, 8'h0c, 0, {2'b11, 32'h0});
        report_and_stop();
    end
endmodule
`default_nettype wire
